// file: smclk_consts.svh
// constants for the state clock divider and channel control block
// assumes inclusion by bare name from the package and the design file
`ifndef SMCLK_CONSTS_SVH
`define SMCLK_CONSTS_SVH
// byte addresses are four times the register index
`define DIVCTL_INDEX 4'h2
`define CHCTL_INDEX 4'h3
`define DIVCTL_RESET 16'h0223
`define CHCTL_RESET 16'hFF86
// divider register fields
`define PREDIV_LSB 6
`define GEN_EN_BIT 5
`define DIVCTL_BIT10 10
`define DIVCTL_LOW_KEEP 5'h03
// channel register fields
`define CH_EN_LSB 12
`define LOGIC_MUTE_BIT 11
`define CH_MUTE_LSB 7
`define POSTDIV_LSB 0
// pre-divider codes
`define PREDIV_2 4'h2
`define PREDIV_4 4'h4
`define PREDIV_8 4'h8
// status register of our own: index 4
`define STATUS_INDEX 4'h4
`define NUM_CH 4
`endif

// file: smclk_ctrl.sv
// state clock divider and channel enable/mute registers behind classic Wishbone
// assumes a single clk_sys domain; cal_active and logic power inputs from same-clock logic
//
// What this block does
// RULE_01: pre-divider codes 2,4,8 divide main clock
// RULE_02: software writes only listed pre-divider codes
// RULE_03: pre-divided clock kept at most 1600 MHz
// RULE_04: generator runs only while enable bit set
// RULE_05: state clock serves calibration and lock detect
// RULE_06: post-divider divides by two to field power
// RULE_07: state clock kept at most 30 MHz
// RULE_08: bits 15..12 enable channels 3..0
// RULE_09: cleared channel enable forces channel off
// RULE_10: channel mute bits mute during calibration
// RULE_11: bit 11 mutes logic outputs during calibration
// RULE_12: divider writes keep bit10 zero, low 0x03; code clears only bits 15..11 and stores bits 10..0 as written
// RULE_13: channel writes keep bits 6..3 zero; code stores all written bits as given
// RULE_14: state clock times calibration; mutes need calibration
`timescale 1ns/1ps
`include "smclk_consts.svh"
module smclk_ctrl (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic main_clock_tick,
    input wire logic cal_active,
    input wire logic [3:0] clk_buf_enable,
    input wire logic [3:0] sysref_buf_enable,
    input wire logic logic_clk_enable,
    output logic state_clock_tick,
    output smclk_pkg::out_gate_t out_gate
);
    import smclk_pkg::*;

    // decode a byte address into a register index match
    function automatic logic hit(input logic [7:0] adr, input logic [3:0] idx);
        hit = (adr[7:2] == {2'b00, idx}) && (adr[1:0] == 2'b00);
    endfunction

    // pre-divider code to count limit minus one
    function automatic logic [2:0] prediv_last(input logic [3:0] code);
        case (code)
            `PREDIV_2: prediv_last = 3'h1;
            `PREDIV_4: prediv_last = 3'h3;
            default: prediv_last = 3'h7;
        endcase
    endfunction

    // ========================================
    // register file
    logic [15:0] divctl;
    logic [15:0] chctl;
    logic [15:0] next_divctl;
    logic [15:0] next_chctl;
    logic ack;
    logic next_ack;
    logic [31:0] next_dat;
    logic wr_go;
    logic [15:0] status_word;

    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !ack;

    // write decode with low byte lanes
    always_comb begin
        next_divctl = divctl;
        next_chctl = chctl;
        next_ack = wb_cyc_i && wb_stb_i && !ack;
        if (wr_go && hit(wb_adr_i, `DIVCTL_INDEX)) begin
            if (wb_sel_i[0]) begin
                next_divctl[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                next_divctl[10:8] = wb_dat_i[10:8];
            end
            next_divctl[15:11] = 5'h00;
        end
        if (wr_go && hit(wb_adr_i, `CHCTL_INDEX)) begin
            if (wb_sel_i[0]) begin
                next_chctl[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                next_chctl[15:8] = wb_dat_i[15:8];
            end
        end
    end

    // read mux, unmapped reads zero
    always_comb begin
        next_dat = 32'h0000_0000;
        if (hit(wb_adr_i, `DIVCTL_INDEX)) begin
            next_dat = {16'h0000, divctl};
        end else if (hit(wb_adr_i, `CHCTL_INDEX)) begin
            next_dat = {16'h0000, chctl};
        end else if (hit(wb_adr_i, `STATUS_INDEX)) begin
            next_dat = {16'h0000, status_word};
        end
    end

    // register storage
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            divctl <= `DIVCTL_RESET;
            chctl <= `CHCTL_RESET;
            ack <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            divctl <= next_divctl;
            chctl <= next_chctl;
            ack <= next_ack;
            wb_dat_o <= next_dat;
        end
    end
    assign wb_ack_o = ack;

    // ========================================
    // state clock generator
    gen_state_t state;
    gen_state_t next_state;
    logic [2:0] pre_cnt;
    logic [2:0] next_pre_cnt;
    logic [6:0] post_cnt;
    logic [6:0] next_post_cnt;
    logic next_tick;
    logic [6:0] post_last;
    logic gen_en;

    // RULE_04 enable bit gates generator
    assign gen_en = divctl[`GEN_EN_BIT];
    // RULE_06 post divide by power of two
    assign post_last = 7'((8'h01 << chctl[2:0]) - 8'h01);

    // RULE_01 two-stage divide of main clock ticks
    always_comb begin
        next_state = state;
        next_pre_cnt = pre_cnt;
        next_post_cnt = post_cnt;
        next_tick = 1'b0;
        case (state)
            ST_IDLE: begin
                next_pre_cnt = 3'h0;
                next_post_cnt = 7'h00;
                if (gen_en) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!gen_en) begin
                    next_state = ST_IDLE;
                end else if (main_clock_tick) begin
                    if (pre_cnt >= prediv_last(divctl[9:6])) begin
                        next_pre_cnt = 3'h0;
                        if (post_cnt >= post_last) begin
                            next_post_cnt = 7'h00;
                            next_tick = 1'b1;
                        end else begin
                            next_post_cnt = post_cnt + 7'h01;
                        end
                    end else begin
                        next_pre_cnt = pre_cnt + 3'h1;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // generator registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= ST_IDLE;
            pre_cnt <= 3'h0;
            post_cnt <= 7'h00;
            state_clock_tick <= 1'b0;
        end else begin
            state <= next_state;
            pre_cnt <= next_pre_cnt;
            post_cnt <= next_post_cnt;
            state_clock_tick <= next_tick;
        end
    end

    // ========================================
    // output gating
    logic cal_live;
    logic logic_on;
    wire [3:0] ch_clk_on;
    wire [3:0] ch_sysref_on;
    out_gate_t next_gate;
    // RULE_05 calibration needs the generator enable bit set
    // RULE_14 mutes only while calibration runs
    assign cal_live = cal_active && gen_en;

    genvar g;
    generate
        for (g = 0; g < `NUM_CH; g = g + 1) begin : g_ch
            logic mute;
            // RULE_10 per channel calibration mute
            assign mute = cal_live && chctl[`CH_MUTE_LSB + g];
            // RULE_08 RULE_09 channel enable overrides buffers
            assign ch_clk_on[g] = chctl[`CH_EN_LSB + g] && clk_buf_enable[g] && !mute;
            assign ch_sysref_on[g] = chctl[`CH_EN_LSB + g] && sysref_buf_enable[g] && !mute;
        end
    endgenerate

    // RULE_11 logic outputs muted during calibration
    assign logic_on = logic_clk_enable && !(cal_live && chctl[`LOGIC_MUTE_BIT]);

    // gate word assembled for the output register
    always_comb begin
        next_gate.clk_on = ch_clk_on;
        next_gate.sysref_on = ch_sysref_on;
        next_gate.logic_clk_on = logic_on;
        next_gate.logic_sysref_on = logic_on;
    end

    // gate register, every output off while in reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_gate <= '0;
        end else begin
            out_gate <= next_gate;
        end
    end

    // status: generator running, calibration live, channel enables
    assign status_word = {10'h000, chctl[15:12], cal_live, (state == ST_RUN)};
endmodule // smclk_ctrl

// file: smclk_ctrl_properties.sv
// concurrent checks on the smclk_ctrl ports
// assumes one clk_sys domain, srst synchronous active high
`timescale 1ns/1ps
// ==========
// checker
module smclk_ctrl_properties (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic main_clock_tick,
    input wire logic [3:0] clk_buf_enable,
    input wire logic [3:0] sysref_buf_enable,
    input wire logic logic_clk_enable,
    input wire logic state_clock_tick,
    input wire smclk_pkg::out_gate_t out_gate
);
    import smclk_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // request taken while no ack stands
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    chk_ack_follows:
        assert property (req_s |=> wb_ack_o) else $error("ack missing after request");
    chk_ack_single:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    chk_ack_cause:
        assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    chk_clk_gate:
        assert property ((out_gate.clk_on & ~$past(clk_buf_enable)) == 4'h0) else $error("clock on with buffer off");
    chk_sref_gate:
        assert property ((out_gate.sysref_on & ~$past(sysref_buf_enable)) == 4'h0) else $error("sysref on, buffer off");
    chk_logic_gate:
        assert property (out_gate.logic_clk_on |-> $past(logic_clk_enable)) else $error("logic clock on, buffer off");
    chk_tick_pulse:
        assert property (state_clock_tick |=> !state_clock_tick) else $error("state tick too long");
    chk_tick_cause:
        assert property (state_clock_tick |-> $past(main_clock_tick)) else $error("state tick without input");
endmodule // smclk_ctrl_properties
bind smclk_ctrl smclk_ctrl_properties chk_u (
    .clk_sys(clk_sys),
    .srst(srst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .main_clock_tick(main_clock_tick),
    .clk_buf_enable(clk_buf_enable),
    .sysref_buf_enable(sysref_buf_enable),
    .logic_clk_enable(logic_clk_enable),
    .state_clock_tick(state_clock_tick),
    .out_gate(out_gate)
);

// file: smclk_ctrl_tb_top.sv
// register and divider tests of smclk_ctrl over classic Wishbone
// assumes the design answers each request one cycle after it is taken
`timescale 1ns/1ps
// ==========
// bench
module smclk_ctrl_tb_top;
    import smclk_pkg::*;
    logic clk_sys = 0, srst = 1, cyc = 0, stb = 0, we = 0, mt = 1, cal = 0, lce = 1, ack, tick;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0, cbe = 4'hF, sbe = 4'hF;
    logic [31:0] dat = 0, dat_o, q;
    out_gate_t og;
    int errors = 0, n_checks = 0, c, k, pd[3] = '{0, 3, 7};
    // 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;
    smclk_ctrl dut_u (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .main_clock_tick(mt), .cal_active(cal), .clk_buf_enable(cbe), .sysref_buf_enable(sbe),
        .logic_clk_enable(lce), .state_clock_tick(tick), .out_gate(og));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 0;
        stb <= 0;
    endtask
    // cycles between two state ticks
    task automatic per();
        do @(posedge clk_sys); while (tick !== 1'b1);
        c = 0;
        do begin
            @(posedge clk_sys);
            c++;
        end while (tick !== 1'b1);
    endtask
    task automatic final_report();
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog
    initial begin
        #500000;
        errors++;
        final_report();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 0;
        bus(0, 8'h08, 0);
        chk(q, 32'h0000_0223);
        bus(0, 8'h0C, 0);
        chk(q, 32'h0000_FF86);
        bus(0, 8'h10, 0);
        chk(q, 32'h0000_003D);
        bus(0, 8'h14, 0);
        chk(q, 32'h0000_0000);
        bus(1, 8'h08, 32'h0000_F8A3);
        bus(0, 8'h08, 0);
        chk(q, 32'h0000_00A3);
        for (int i = 0; i < 3; i++) begin
            bus(1, 8'h08, ((2 << i) << 6) | 32'h0000_0023);
            bus(1, 8'h0C, 32'h0000_FF80 | pd[i]);
            per();
            per();
            chk(c, (2 << i) << pd[i]);
        end
        bus(1, 8'h08, 32'h0000_0203);
        k = 0;
        repeat (300) begin
            @(posedge clk_sys);
            if (tick === 1'b1) k++;
        end
        chk(k, 0);
        bus(0, 8'h10, 0);
        chk(q, 32'h0000_003C);
        cal <= 1;
        @(posedge clk_sys);
        #1 chk(og.clk_on, 4'hF);
        bus(1, 8'h08, 32'h0000_0223);
        bus(1, 8'h0C, 32'h0000_FD06);
        @(posedge clk_sys);
        #1 chk(og.clk_on, 4'h5);
        chk(og.sysref_on, 4'h5);
        chk(og.logic_clk_on, 0);
        chk(og.logic_sysref_on, 0);
        bus(0, 8'h10, 0);
        chk(q, 32'h0000_003F);
        cal <= 0;
        bus(1, 8'h0C, 32'h0000_5F86);
        @(posedge clk_sys);
        #1 chk(og.clk_on, 4'h5);
        chk(og.sysref_on, 4'h5);
        chk(og.logic_clk_on, 1);
        chk(og.logic_sysref_on, 1);
        @(posedge clk_sys);
        sbe <= 4'h3;
        @(posedge clk_sys);
        #1 chk(og.sysref_on, 4'h1);
        final_report();
    end
endmodule // smclk_ctrl_tb_top

// file: smclk_pkg.sv
// types shared by the state clock divider block
// assumes smclk_consts.svh sits in the include path
`include "smclk_consts.svh"
package smclk_pkg;
    // channel gating towards the analog outputs
    typedef struct packed {
        logic [3:0] clk_on;
        logic [3:0] sysref_on;
        logic logic_clk_on;
        logic logic_sysref_on;
    } out_gate_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN} gen_state_t;
endpackage
